// ---- kpc_pkg.sv ----
// Shared constants and types of the keypad companion command block
package kpc_pkg;

  // Timing
  localparam int          CLK_NS       = 10;
  localparam int          ACT_UNIT_NS  = 4000000;
  localparam int          ACT_UNIT_CYC = ACT_UNIT_NS / CLK_NS;
  localparam logic [7:0]  ACT_DEF      = 8'h7D;

  // Command codes
  localparam logic [7:0]  CMD_ID       = 8'h80;
  localparam logic [7:0]  CMD_CFG      = 8'h81;
  localparam logic [7:0]  CMD_INT      = 8'h82;
  localparam logic [7:0]  CMD_RST      = 8'h83;
  localparam logic [7:0]  CMD_PULL     = 8'h84;
  localparam logic [7:0]  CMD_DIR_WR   = 8'h85;
  localparam logic [7:0]  CMD_STATE_WR = 8'h86;
  localparam logic [7:0]  CMD_DIR_RD   = 8'h87;
  localparam logic [7:0]  CMD_STATE_RD = 8'h88;
  localparam logic [7:0]  CMD_QUEUE    = 8'h89;
  localparam logic [7:0]  CMD_REPEAT   = 8'h8A;
  localparam logic [7:0]  CMD_ACTIVE   = 8'h8B;
  localparam logic [7:0]  CMD_ERR      = 8'h8C;
  localparam logic [7:0]  RESET_KEY    = 8'hAA;

  // Configuration register
  localparam logic [7:0]  CFG_DEF      = 8'h80;
  localparam int          CFG_IRQ_PP   = 7;

  // Interrupt code bits
  localparam int          INT_KEY      = 0;
  localparam int          INT_ERR      = 3;
  localparam int          INT_AWAITING_INITIALISATION_FLAG   = 4;
  localparam logic [7:0]  INT_PWM_MASK = 8'hE0;

  // Error code bits
  localparam int          ERR_BAD_PARAMETER_FLAG   = 0;
  localparam int          ERR_UNKNOWN_COMMAND_FLAG   = 1;
  localparam int          ERR_TOO_MANY_KEYS_FLAG   = 2;
  localparam int          ERR_QOVF     = 6;

  // Bus address and queue
  localparam logic [6:0]  ADDR_BASE    = 7'h42;
  localparam int          QUEUE_DEPTH  = 14;
  localparam logic [7:0]  MAKER_DEF    = 8'h5A;
  localparam logic [7:0]  REV_DEF      = 8'h01;

  // Register map
  localparam int          AXI_AW       = 4;
  localparam logic [3:0]  OFF_QUEUE    = 4'h0;
  localparam logic [3:0]  OFF_EVENTS   = 4'h4;
  localparam logic [3:0]  OFF_STATUS   = 4'h8;
  localparam logic [3:0]  OFF_PORTS    = 4'hC;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_ADDR  = 3'b001,
    S_AACK  = 3'b010,
    S_RX    = 3'b011,
    S_RXACK = 3'b100,
    S_LOAD  = 3'b101,
    S_TX    = 3'b110,
    S_TXACK = 3'b111
  } kpc_bus_st_t;

endpackage

// ---- kpc_link_if.sv ----
// Link between the two-wire engine and the command interpreter
`timescale 1ns/1ns
interface kpc_link_if;
  logic       start;
  logic       stop;
  logic       act;
  logic       hit;
  logic       rw;
  logic       rx_vld;
  logic [7:0] rx_byte;
  logic       tx_req;
  logic       tx_rdy;
  logic [7:0] tx_byte;
  logic       tx_done;
  logic       ack_en;
  modport eng (output start, stop, act, hit, rw, rx_vld, rx_byte, tx_req, tx_done,
               input tx_rdy, tx_byte, ack_en);
  modport cmd (input start, stop, act, hit, rw, rx_vld, rx_byte, tx_req, tx_done,
               output tx_rdy, tx_byte, ack_en);
endinterface

// ---- kpc_i2c_slave.sv ----
// Two-wire slave engine: bit timing, address match, acknowledge, stretch
`timescale 1ns/1ns
module kpc_i2c_slave
  import kpc_pkg::*;
(
  input  logic       aclk,
  input  logic       aresetn,
  input  logic       scl_i,
  input  logic       sda_i,
  input  logic [6:0] addr,
  output logic       scl_oe,
  output logic       sda_oe,
  kpc_link_if.eng    lk
);

  logic        scl_m_q, scl_s_q, scl_p_q;
  logic        sda_m_q, sda_s_q, sda_p_q;
  logic [2:0]  cnt_q;
  logic        full_q;
  logic        ack_q;
  logic [7:0]  sh_q;
  kpc_bus_st_t st_q;

  wire scl_rise = scl_s_q & ~scl_p_q;
  wire scl_fall = ~scl_s_q & scl_p_q;
  wire start_w  = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  wire stop_w   = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  wire match_w  = (sh_q[7:1] == addr) & lk.ack_en;

  assign lk.start   = start_w;
  assign lk.stop    = stop_w;
  assign lk.act     = (scl_s_q ^ scl_p_q) | (sda_s_q ^ sda_p_q);
  assign lk.hit     = (st_q == S_ADDR) & scl_fall & full_q & match_w;
  assign lk.rw      = sh_q[0];
  assign lk.rx_vld  = (st_q == S_RX) & scl_fall & full_q;
  assign lk.rx_byte = sh_q;
  assign lk.tx_req  = ((st_q == S_AACK) & scl_fall & sh_q[0]) | ((st_q == S_TXACK) & scl_fall & ack_q);
  assign lk.tx_done = (st_q == S_TXACK) & scl_rise;

  // Pins are asynchronous, so two stages before any use
  always_ff @(posedge aclk)
  begin
    scl_m_q <= scl_i;
    scl_s_q <= scl_m_q;
    scl_p_q <= scl_s_q;
    sda_m_q <= sda_i;
    sda_s_q <= sda_m_q;
    sda_p_q <= sda_s_q;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q   <= S_IDLE;
      cnt_q  <= 3'h0;
      full_q <= 1'b0;
      ack_q  <= 1'b0;
      sh_q   <= 8'h00;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end
    else if (start_w)
    begin
      st_q   <= S_ADDR;
      cnt_q  <= 3'h0;
      full_q <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end
    else if (stop_w)
    begin
      st_q   <= S_IDLE;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end
    else
    begin
      case (st_q)
        S_ADDR, S_RX:
        begin
          if (scl_rise)
          begin
            sh_q   <= {sh_q[6:0], sda_s_q};
            cnt_q  <= cnt_q + 3'h1;
            full_q <= (cnt_q == 3'h7);
          end
          else if (scl_fall && full_q)
          begin
            full_q <= 1'b0;
            if (st_q == S_RX)
            begin
              st_q   <= S_RXACK;
              sda_oe <= 1'b1;
            end
            else if (match_w)
            begin
              st_q   <= S_AACK;
              sda_oe <= 1'b1;
            end
            else
              st_q <= S_IDLE;
          end
        end
        S_AACK, S_RXACK:
        begin
          if (scl_fall)
          begin
            sda_oe <= 1'b0;
            if (st_q == S_AACK && sh_q[0])
            begin
              st_q   <= S_LOAD;
              scl_oe <= 1'b1;
            end
            else
              st_q <= S_RX;
          end
        end
        S_LOAD:
        begin
          // Low phase is held until the reply byte is on hand
          if (lk.tx_rdy)
          begin
            st_q   <= S_TX;
            scl_oe <= 1'b0;
            sh_q   <= lk.tx_byte;
            sda_oe <= ~lk.tx_byte[7];
            cnt_q  <= 3'h0;
            full_q <= 1'b0;
          end
        end
        S_TX:
        begin
          if (scl_rise)
          begin
            cnt_q  <= cnt_q + 3'h1;
            full_q <= (cnt_q == 3'h7);
          end
          else if (scl_fall)
          begin
            if (full_q)
            begin
              st_q   <= S_TXACK;
              full_q <= 1'b0;
              sda_oe <= 1'b0;
            end
            else
            begin
              sh_q   <= {sh_q[6:0], 1'b0};
              sda_oe <= ~sh_q[6];
            end
          end
        end
        S_TXACK:
        begin
          if (scl_rise)
            ack_q <= ~sda_s_q;
          else if (scl_fall)
          begin
            if (ack_q)
            begin
              st_q   <= S_LOAD;
              scl_oe <= 1'b1;
            end
            else
              st_q <= S_IDLE;
          end
        end
        default:
          st_q <= S_IDLE;
      endcase
    end
  end

endmodule

// ---- kpc_cmd_top.sv ----
// Command interpreter of the keypad companion with its register slave
//
// Overview of operation
// - Bus activity in halt wakes the device; the first address goes unacknowledged.
// - Device acknowledges by holding data low during the following clock high phase.
// - Device may stretch the clock low while busy; host waits for release.
// - Identification read returns maker code, then revision number.
// - Configuration write loads one data byte into the configuration register.
// - Interrupt code read returns the code, clears it, releases service request.
// - Awaiting-initialisation flag survives that read until a configuration write arrives.
// - Soft reset only with the key byte; any other byte is an error.
// - Pull write: two bytes, per pin 0 pullup, 1 pulldown.
// - Direction write: two bytes, per pin 0 input, 1 output.
// - State write: two bytes, weak pullup for inputs, level for outputs.
// - Direction read returns two bytes of pin directions.
// - State read returns two bytes of current pin states.
// - Queue read returns stored event codes and advances; fourteen codes at most.
// - Repeat read returns the previous codes without advancing the queue.
// - Active time write takes n from 1 to 255; n times 4 ms, default 500 ms.
// - Error code read returns the code and then clears it.
// - Interrupt code: key 0, error 3, awaiting init 4, script ends 5 to 7.
// - Error code: bad parameter 0, unknown 1, too many keys 2, overflow 6.
// - Two sampled pins select addresses 0x42 to 0x45; open pins give 0x45.
`timescale 1ns/1ns
module kpc_cmd_top
  import kpc_pkg::*;
#(
  parameter int         TICK_CYCLES = ACT_UNIT_CYC,
  parameter int         Q_DEPTH     = QUEUE_DEPTH,
  parameter logic [7:0] MAKER_CODE  = MAKER_DEF,  // arbitrary value
  parameter logic [7:0] REV_CODE    = REV_DEF     // arbitrary value
)(
  input  logic              aclk,
  input  logic              aresetn,
  input  logic [AXI_AW-1:0] awaddr,
  input  logic              awvalid,
  output logic              awready,
  input  logic [31:0]       wdata,
  input  logic [3:0]        wstrb,
  input  logic              wvalid,
  output logic              wready,
  output logic [1:0]        bresp,
  output logic              bvalid,
  input  logic              bready,
  input  logic [AXI_AW-1:0] araddr,
  input  logic              arvalid,
  output logic              arready,
  output logic [31:0]       rdata,
  output logic [1:0]        rresp,
  output logic              rvalid,
  input  logic              rready,
  input  logic              scl_i,
  output logic              scl_o,
  output logic              scl_oe,
  input  logic              sda_i,
  output logic              sda_o,
  output logic              sda_oe,
  input  logic [1:0]        addr_sel,
  input  logic [15:0]       gpio_in,
  output logic [15:0]       gpio_dir,
  output logic [15:0]       gpio_level,
  output logic [15:0]       gpio_pull_dn,
  output logic              irq_n_o,
  output logic              irq_oe,
  output logic              halted
);

  localparam int TW = $clog2(TICK_CYCLES + 1);

  kpc_link_if lk ();

  logic [1:0]        sel_m_q, sel_s_q;
  logic [15:0]       gin_m_q, gin_s_q;
  logic [7:0]        cmd_q, cfg_q, act_q, int_q, err_q, tx_byte_q;
  logic              first_q, tx_rdy_q, soft_rst_q, block_q;
  logic [1:0]        idx_q;
  logic [3:0]        rd_idx_q;
  logic [TW-1:0]     tick_q;
  logic [7:0]        act_cnt_q;
  logic [7:0]        q_mem [Q_DEPTH];
  logic [3:0]        head_q, cnt_q, prev_head_q, prev_n_q;
  logic              awrdy_q, wrdy_q, bvalid_q, arrdy_q, rvalid_q;
  logic [AXI_AW-1:0] aw_addr_q;
  logic [31:0]       wdata_q, rdata_q;
  logic [3:0]        wstrb_q;
  logic [1:0]        bresp_q, rresp_q;
  logic              irq_n_q, irq_oe_q;

  function automatic logic [3:0] qwrap(input logic [4:0] v);
    qwrap = (v >= 5'(Q_DEPTH)) ? 4'(v - 5'(Q_DEPTH)) : v[3:0];
  endfunction

  kpc_i2c_slave u_eng (
    .aclk    (aclk),
    .aresetn (aresetn),
    .scl_i   (scl_i),
    .sda_i   (sda_i),
    .addr    (ADDR_BASE + {5'h00, sel_s_q}),
    .scl_oe  (scl_oe),
    .sda_oe  (sda_oe),
    .lk      (lk)
  );

  assign scl_o   = 1'b0;
  assign sda_o   = 1'b0;
  assign awready = awrdy_q;
  assign wready  = wrdy_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = arrdy_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;
  assign irq_n_o = irq_n_q;
  assign irq_oe  = irq_oe_q;

  // Host byte decode
  wire rst_all  = ~aresetn | soft_rst_q;
  wire rx_cmd   = lk.rx_vld & first_q;
  wire rx_dat   = lk.rx_vld & ~first_q;
  wire cmd_ok   = (lk.rx_byte >= CMD_ID) && (lk.rx_byte <= CMD_ERR);
  wire unk_w    = rx_cmd & ~cmd_ok;
  wire cfg_wr   = rx_dat & (cmd_q == CMD_CFG);
  wire rst_wr   = rx_dat & (cmd_q == CMD_RST);
  wire rst_good = rst_wr & (lk.rx_byte == RESET_KEY);
  wire act_wr   = rx_dat & (cmd_q == CMD_ACTIVE);
  wire bad_w    = (rst_wr & ~rst_good) | (act_wr & (lk.rx_byte == 8'h00));
  wire port_wr  = rx_dat & (idx_q < 2'h2);
  wire int_done = lk.tx_done & (cmd_q == CMD_INT);
  wire err_done = lk.tx_done & (cmd_q == CMD_ERR);
  wire pop_w    = lk.tx_done & (cmd_q == CMD_QUEUE) & (cnt_q != 4'h0);

  // Register slave decode
  wire wr_go    = ~awrdy_q & ~wrdy_q & ~bvalid_q;
  wire w_queue  = wr_go & (aw_addr_q == OFF_QUEUE) & wstrb_q[0];
  wire w_events = wr_go & (aw_addr_q == OFF_EVENTS) & wstrb_q[0];
  wire w_map    = (aw_addr_q == OFF_QUEUE) | (aw_addr_q == OFF_EVENTS);
  wire push_w   = w_queue & ((cnt_q != 4'(Q_DEPTH)) | pop_w);
  wire ovf_w    = w_queue & ~push_w;
  wire too_many_keys_flag_w = w_events & wdata_q[ERR_TOO_MANY_KEYS_FLAG];

  // Interrupt and error codes
  wire [7:0] err_set = ({7'h00, bad_w} << ERR_BAD_PARAMETER_FLAG) | ({7'h00, unk_w} << ERR_UNKNOWN_COMMAND_FLAG)
                     | ({7'h00, too_many_keys_flag_w} << ERR_TOO_MANY_KEYS_FLAG) | ({7'h00, ovf_w} << ERR_QOVF);
  wire [7:0] int_set = ({7'h00, push_w} << INT_KEY) | ({7'h00, |err_set} << INT_ERR)
                     | (w_events ? (wdata_q[7:0] & INT_PWM_MASK) : 8'h00);
  wire [7:0] awaiting_initialisation_flag_m = 8'h01 << INT_AWAITING_INITIALISATION_FLAG;
  wire [7:0] int_clr  = (int_done ? ~awaiting_initialisation_flag_m : 8'h00) | (cfg_wr ? awaiting_initialisation_flag_m : 8'h00);
  wire [7:0] int_d    = (int_q & ~int_clr) | int_set;

  // Reply byte selection
  wire [7:0] q_head  = (cnt_q != 4'h0) ? q_mem[head_q] : 8'h00;
  wire [7:0] q_rep   = (rd_idx_q < prev_n_q) ? q_mem[qwrap({1'b0, prev_head_q} + {1'b0, rd_idx_q})] : 8'h00;
  wire       hi_w    = rd_idx_q[0];
  wire [7:0] rd_byte =
      (cmd_q == CMD_ID)       ? (hi_w ? REV_CODE : MAKER_CODE) :
      (cmd_q == CMD_INT)      ? int_q :
      (cmd_q == CMD_DIR_RD)   ? (hi_w ? gpio_dir[15:8] : gpio_dir[7:0]) :
      (cmd_q == CMD_STATE_RD) ? (hi_w ? gin_s_q[15:8] : gin_s_q[7:0]) :
      (cmd_q == CMD_QUEUE)    ? q_head :
      (cmd_q == CMD_REPEAT)   ? q_rep :
      (cmd_q == CMD_ERR)      ? err_q : 8'h00;

  assign lk.tx_byte = tx_byte_q;
  assign lk.tx_rdy  = tx_rdy_q;
  assign lk.ack_en  = ~halted & ~block_q;

  always_ff @(posedge aclk)
  begin
    sel_m_q <= addr_sel;
    sel_s_q <= sel_m_q;
    gin_m_q <= gpio_in;
    gin_s_q <= gin_m_q;
  end

  // Transfer tracking
  always_ff @(posedge aclk)
  begin
    if (rst_all)
    begin
      cmd_q      <= 8'h00;
      first_q    <= 1'b0;
      idx_q      <= 2'h0;
      rd_idx_q   <= 4'h0;
      tx_byte_q  <= 8'h00;
      tx_rdy_q   <= 1'b0;
      soft_rst_q <= 1'b0;
    end
    else
    begin
      tx_rdy_q   <= lk.tx_req;
      soft_rst_q <= rst_good;
      if (lk.hit)
      begin
        first_q  <= ~lk.rw;
        idx_q    <= 2'h0;
        rd_idx_q <= 4'h0;
      end
      else if (rx_cmd)
      begin
        cmd_q   <= lk.rx_byte;
        first_q <= 1'b0;
      end
      else if (rx_dat && idx_q != 2'h3)
        idx_q <= idx_q + 2'h1;
      if (lk.tx_req)
        tx_byte_q <= rd_byte;
      if (lk.tx_done)
        rd_idx_q <= rd_idx_q + 4'h1;
    end
  end

  // Configuration and port registers
  always_ff @(posedge aclk)
  begin
    if (rst_all)
    begin
      cfg_q        <= CFG_DEF;
      act_q        <= ACT_DEF;
      gpio_dir     <= 16'h0000;
      gpio_level   <= 16'h0000;
      gpio_pull_dn <= 16'h0000;
    end
    else
    begin
      if (cfg_wr)
        cfg_q <= lk.rx_byte;
      if (act_wr && lk.rx_byte != 8'h00)
        act_q <= lk.rx_byte;
      if (port_wr && cmd_q == CMD_PULL)
        gpio_pull_dn[idx_q[0]*8 +: 8] <= lk.rx_byte;
      if (port_wr && cmd_q == CMD_DIR_WR)
        gpio_dir[idx_q[0]*8 +: 8] <= lk.rx_byte;
      if (port_wr && cmd_q == CMD_STATE_WR)
        gpio_level[idx_q[0]*8 +: 8] <= lk.rx_byte;
    end
  end

  // Codes and service request; a new event wins over a clear
  always_ff @(posedge aclk)
  begin
    if (rst_all)
    begin
      int_q    <= awaiting_initialisation_flag_m;
      err_q    <= 8'h00;
      irq_n_q  <= 1'b1;
      irq_oe_q <= 1'b0;
    end
    else
    begin
      int_q    <= int_d;
      err_q    <= (err_q & ~{8{err_done}}) | err_set;
      irq_n_q  <= ~(|int_q);
      irq_oe_q <= cfg_q[CFG_IRQ_PP] | (|int_q);
    end
  end

  // Event queue; pops are taken as each code is clocked out
  always_ff @(posedge aclk)
  begin
    if (rst_all)
    begin
      head_q      <= 4'h0;
      cnt_q       <= 4'h0;
      prev_head_q <= 4'h0;
      prev_n_q    <= 4'h0;
    end
    else
    begin
      if (push_w)
        q_mem[qwrap({1'b0, head_q} + {1'b0, cnt_q})] <= wdata_q[7:0];
      if (pop_w)
        head_q <= qwrap({1'b0, head_q} + 5'h01);
      cnt_q <= cnt_q + {3'h0, push_w} - {3'h0, pop_w};
      if (lk.tx_req && cmd_q == CMD_QUEUE && rd_idx_q == 4'h0)
      begin
        prev_head_q <= head_q;
        prev_n_q    <= 4'h0;
      end
      else if (pop_w)
        prev_n_q <= prev_n_q + 4'h1;
    end
  end

  // Active time and halt; the divider stops with the internal clock
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      halted    <= 1'b0;
      block_q   <= 1'b0;
      tick_q    <= '0;
      act_cnt_q <= ACT_DEF;
    end
    else if (lk.act)
    begin
      halted    <= 1'b0;
      tick_q    <= '0;
      act_cnt_q <= act_q;
      if (halted)
        block_q <= 1'b1;
      else if (lk.stop)
        block_q <= 1'b0;
    end
    else if (!halted)
    begin
      if (tick_q == TW'(TICK_CYCLES - 1))
      begin
        tick_q    <= '0;
        act_cnt_q <= act_cnt_q - 8'h01;
        if (act_cnt_q == 8'h01)
          halted <= 1'b1;
      end
      else
        tick_q <= tick_q + TW'(1);
    end
  end

  // Register slave: address and data are taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awrdy_q   <= 1'b1;
      wrdy_q    <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      aw_addr_q <= '0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end
    else
    begin
      if (awvalid && awrdy_q)
      begin
        awrdy_q   <= 1'b0;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wrdy_q)
      begin
        wrdy_q  <= 1'b0;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (wr_go)
      begin
        bvalid_q <= 1'b1;
        bresp_q  <= w_map ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_q && bready)
      begin
        bvalid_q <= 1'b0;
        awrdy_q  <= 1'b1;
        wrdy_q   <= 1'b1;
      end
    end
  end

  wire [31:0] rd_map =
      (araddr == OFF_QUEUE)  ? {28'h0, cnt_q} :
      (araddr == OFF_EVENTS) ? {16'h0, gpio_pull_dn} :
      (araddr == OFF_STATUS) ? {act_q, 7'h00, halted, err_q, int_q} :
      (araddr == OFF_PORTS)  ? {gpio_level, gpio_dir} : 32'h0000_0000;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arrdy_q  <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end
    else if (arvalid && arrdy_q)
    begin
      arrdy_q  <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q  <= rd_map;
      rresp_q  <= (araddr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_q && rready)
    begin
      rvalid_q <= 1'b0;
      arrdy_q  <= 1'b1;
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_reset_pulse;
    soft_rst_q ##1 (cfg_q == CFG_DEF && int_q[INT_AWAITING_INITIALISATION_FLAG]);
  endsequence

  wake_nack_a: assert property ((halted && lk.act) |=> (!halted && block_q && !lk.ack_en))
    else $error("wake did not block the first address");
  irq_follow_a: assert property ((|int_q && !soft_rst_q) |=> (!irq_n_q && irq_oe_q))
    else $error("service request not asserted");
  awaiting_initialisation_flag_hold_a: assert property ((int_q[INT_AWAITING_INITIALISATION_FLAG] && int_done && !cfg_wr) |=> int_q[INT_AWAITING_INITIALISATION_FLAG])
    else $error("awaiting-init flag lost on code read");
  err_clear_a: assert property ((err_done && err_set == 8'h00 && !soft_rst_q) |=> err_q == 8'h00)
    else $error("error code not cleared");
  unk_cmd_a: assert property (unk_w |=> (err_q[ERR_UNKNOWN_COMMAND_FLAG] && int_q[INT_ERR]) ##1 !irq_n_q)
    else $error("unknown command not reported");
  cfg_load_a: assert property ((cfg_wr && !soft_rst_q) |=> cfg_q == $past(lk.rx_byte))
    else $error("configuration byte not loaded");
  soft_reset_a: assert property (rst_good |=> s_reset_pulse)
    else $error("soft reset not performed");
  queue_cap_a: assert property (cnt_q <= 4'(Q_DEPTH))
    else $error("queue count above depth");
  reply_ready_a: assert property (lk.tx_req |=> (tx_rdy_q && tx_byte_q == $past(rd_byte)))
    else $error("reply byte not ready one cycle after request");
  wake_hold_a: assert property (lk.act |=> (!halted && act_cnt_q == $past(act_q)))
    else $error("activity did not restart the active time");

endmodule

// ---- kpc_host.sv ----
// Two-wire host master model
`timescale 1ns/1ns
module kpc_host (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_oe,
  output logic      sda_oe
);
  initial
  begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  // Waits out stretching, no fixed bound
  task automatic bit_io(input logic b, output logic r);
    sda_oe = ~b;
    #63 scl_oe = 1'b0;
    while (scl !== 1'b1) #5;
    #62 r = sda;
    scl_oe = 1'b1;
  endtask
  task automatic start();
    sda_oe = 1'b0;
    #62 scl_oe = 1'b0;
    #62 sda_oe = 1'b1;
    #62 scl_oe = 1'b1;
  endtask
  task automatic stop();
    sda_oe = 1'b1;
    #62 scl_oe = 1'b0;
    #62 sda_oe = 1'b0;
    #250;
  endtask
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic rd(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule

// ---- kpc_cmd_top_bench.sv ----
// Self-checking bench of the keypad companion command block
`timescale 1ns/1ns
module kpc_cmd_top_bench;
  import kpc_pkg::*;
  localparam logic [7:0] MK = 8'hC3; // arbitrary value
  localparam logic [7:0] RV = 8'h07; // arbitrary value
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, rd_q;
  logic [1:0] bresp, rresp, addr_sel;
  logic scl_oe, sda_oe, h_scl, h_sda, irq_n_o, halted, ack;
  logic [15:0] gpio_in, gpio_dir, gpio_level, gpio_pull_dn;
  logic [15:0] v [0:2];
  logic [7:0] rb [0:3];
  logic [7:0] evq [$];
  wire scl = ~(scl_oe | h_scl);
  wire sda = ~(sda_oe | h_sda);
  int mismatches, checked, cyc, exp_int, exp_err, seed = 93800;
  kpc_cmd_top #(.TICK_CYCLES(20), .MAKER_CODE(MK), .REV_CODE(RV)) i_kpc_cmd_top (.aclk, .aresetn, .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .scl_i(scl), .scl_o(), .scl_oe, .sda_i(sda), .sda_o(), .sda_oe, .addr_sel,
    .gpio_in, .gpio_dir, .gpio_level, .gpio_pull_dn, .irq_n_o, .irq_oe(), .halted);
  kpc_host i_kpc_host (.scl, .sda, .scl_oe(h_scl), .sda_oe(h_sda));
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] g, e);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic report_and_stop();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    do @(negedge aclk); while (!(awready && wready));
    @(posedge aclk);
    {awvalid, wvalid} <= 2'b00;
    do @(negedge aclk); while (!bvalid);
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a);
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    rd_q = rdata;
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  task automatic do_cmd(input logic [7:0] c, input int nw, input logic [15:0] d, input int nr);
    logic a;
    i_kpc_host.start();
    i_kpc_host.wr(8'h8A, ack);
    i_kpc_host.wr(c, a);
    ack &= a;
    for (int i = 0; i < nw; i++) i_kpc_host.wr(d[8*i+:8], a);
    if (nr > 0)
    begin
      i_kpc_host.start();
      i_kpc_host.wr(8'h8B, a);
      for (int i = 0; i < nr; i++) i_kpc_host.rd(i == nr - 1, rb[i]);
    end
    i_kpc_host.stop();
  endtask
  always @(posedge aclk)
    if (++cyc == 40000)
    begin
      mismatches++;
      report_and_stop();
    end
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    addr_sel = 2'b11;
    gpio_in = 16'($random(seed));
    exp_int = 8'h10;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(irq_n_o, 0);
    axi_rd(OFF_STATUS);
    chk(rd_q[15:0], {8'h00, 8'h10});
    repeat (2400) @(posedge aclk);
    chk(halted, 0);
    repeat (200) @(posedge aclk);
    chk(halted, 1);
    i_kpc_host.start();
    i_kpc_host.wr(8'h8A, ack);
    i_kpc_host.stop();
    chk(ack, 0);
    chk(halted, 0);
    do_cmd(CMD_ID, 0, 0, 2);
    chk({ack, rb[0], rb[1]}, {1'b1, MK, RV});
    do_cmd(CMD_INT, 0, 0, 1);
    chk({irq_n_o, rb[0]}, 9'h010);
    do_cmd(CMD_CFG, 1, 16'h80, 0);
    do_cmd(CMD_INT, 0, 0, 1);
    chk({irq_n_o, rb[0]}, 9'h100);
    for (int k = 0; k < 3; k++)
    begin
      v[k] = 16'($random(seed));
      do_cmd(8'(CMD_PULL + k), 2, v[k], 0);
      chk(k == 0 ? gpio_pull_dn : k == 1 ? gpio_dir : gpio_level, v[k]);
    end
    do_cmd(CMD_DIR_RD, 0, 0, 2);
    chk({rb[1], rb[0]}, v[1]);
    do_cmd(CMD_STATE_RD, 0, 0, 2);
    chk({rb[1], rb[0]}, gpio_in);
    do_cmd(8'h8D, 0, 0, 0);
    exp_int = 8'h08;
    exp_err = 8'h02;
    chk(irq_n_o, 0);
    axi_rd(OFF_STATUS);
    chk(rd_q[15:0], {exp_err[7:0], exp_int[7:0]});
    do_cmd(CMD_RST, 1, 16'h55, 0);
    do_cmd(CMD_ERR, 0, 0, 1);
    chk(rb[0], 8'h03);
    do_cmd(CMD_ERR, 0, 0, 1);
    chk(rb[0], 8'h00);
    repeat (3)
    begin
      evq.push_back(8'($random(seed)));
      axi_wr(OFF_QUEUE, {24'h0, evq[$]});
    end
    for (int j = 0; j < 2; j++)
    begin
      do_cmd(8'(CMD_QUEUE + j), 0, 0, 3);
      for (int k = 0; k < 3; k++) chk(rb[k], evq[k]);
    end
    do_cmd(CMD_ACTIVE, 1, 16'h04, 0);
    repeat (100) @(posedge aclk);
    chk(halted, 1);
    i_kpc_host.start();
    i_kpc_host.wr(8'h01, ack);
    i_kpc_host.stop();
    chk({ack, halted}, 2'b00);
    do_cmd(CMD_RST, 1, 16'hAA, 0);
    chk({ack, irq_n_o, gpio_dir}, {2'b10, 16'h0000});
    report_and_stop();
  end
endmodule
